// File: core/rvfy_pkg.sv
// constants, types and register map of the read verify command handler
// Operation
// - opcodes 40h and 41h start 28-bit verify
// - retry bit of opcode is ignored
// - opcode 42h starts extended 48-bit verify
// - verify never requests or moves sector data
// - 28-bit count of zero means 256
// - sector number is sector or address 7:0
// - cylinder bytes are cylinder or address 23:8
// - head nibble is head or address 27:24
// - 28-bit verify stops at failing sector
// - extended verify stops at failing sector
// - sector count returns sectors not verified
// - return last sector address in layout chosen
// - head nibble returns last head or bits 27:24
// - extended count is two bytes, zero means 65536
// - extended error address readable by high-byte select
package rvfy_pkg;
   localparam int AXI_AW = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // byte addresses of the register words
   localparam logic [7:0] OFF_SCNT = 8'h00;
   localparam logic [7:0] OFF_SNUM = 8'h04;
   localparam logic [7:0] OFF_CYLL = 8'h08;
   localparam logic [7:0] OFF_CYLH = 8'h0C;
   localparam logic [7:0] OFF_DEVHEAD = 8'h10;
   localparam logic [7:0] OFF_CMD_STATUS = 8'h14;
   localparam logic [7:0] OFF_ERROR = 8'h18;
   localparam logic [7:0] OFF_DEVCTL = 8'h1C;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
   // opcodes
   localparam logic [7:0] OP_VFY28 = 8'h40;
   localparam logic [7:0] OP_VFY48 = 8'h42;
   // field positions
   localparam int DH_LBA = 6;
   localparam int DH_DEV = 4;
   localparam int CTL_HOB = 7;
   localparam int ERR_UNC = 6;
   localparam int ERR_IDN = 4;
   localparam int ERR_ABT = 2;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR = 1;
   // reset values
   localparam logic [7:0] DEVHEAD_RST = 8'hA0;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [1:0] IRQ_RST = 2'h0;
   // counts
   localparam logic [16:0] CNT28_ZERO = 17'h00100;
   localparam logic [16:0] CNT48_ZERO = 17'h10000;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_VERIFY = 1'b1
   } rvfy_state_e;

   typedef struct packed {
      logic chs;
      logic ext;
      logic [47:0] addr;
   } rvfy_media_req_s;

   typedef struct packed {
      logic unc;
      logic idnf;
   } rvfy_media_rsp_s;
endpackage : rvfy_pkg

// File: core/rvfy_top.sv
// read verify command handler with AXI4-Lite task file access
`timescale 1ns/1ps
module rvfy_top #(
   parameter int DEV_NUM = 0,
   parameter logic [7:0] SECT_PER_TRK = 8'h3F,
   parameter logic [3:0] HEAD_MAX = 4'hF
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [rvfy_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [rvfy_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output rvfy_pkg::rvfy_media_req_s vfy_req,
   output logic vfy_valid,
   input wire logic vfy_done,
   input wire rvfy_pkg::rvfy_media_rsp_s vfy_rsp,
   output logic irq
);
   rvfy_pkg::rvfy_state_e state_r;
   logic aw_got_r, w_got_r;
   logic [7:0] waddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic bvalid_r, rvalid_r;
   logic [7:0] cur_r [4];
   logic [7:0] prev_r [4];
   logic [7:0] devhead_r, devctl_r, error_r;
   logic st_err_r;
   logic [1:0] irq_stat_r, irq_mask_r;
   logic [16:0] cnt_r;
   logic [47:0] addr_r;
   logic ext_r, chs_r;
   logic wr_fire, wr_known, tf_wr, cmd_wr, is28, is48, cmd_go, cmd_bad;
   logic fin, fin_bad, fin_end;
   logic [16:0] cnt_start, rem;
   logic [47:0] addr_start;
   logic [31:0] rd_val;
   logic rd_known, rd_fire;
   logic [1:0] irq_set, irq_clr;
   logic [7:0] status_val;
   // reset value shared by the byte registers other than device/head
   localparam logic [7:0] ZERO8_W = rvfy_pkg::ZERO8;

   // next sector in chs order or plain linear order
   function automatic logic [47:0] next_addr(input logic [47:0] a,
                                             input logic chs);
      logic [47:0] n;
      n = a + 48'h1;
      if (chs) begin
         n = a;
         if (a[7:0] != SECT_PER_TRK) begin
            n[7:0] = a[7:0] + 8'h01;
         end else begin
            n[7:0] = 8'h01;
            if (a[27:24] != HEAD_MAX) begin
               n[27:24] = a[27:24] + 4'h1;
            end else begin
               n[27:24] = 4'h0;
               n[23:8] = a[23:8] + 16'h0001;
            end
         end
      end
      return n;
   endfunction : next_addr

   function automatic logic known_addr(input logic [7:0] a);
      return (a == rvfy_pkg::OFF_SCNT) || (a == rvfy_pkg::OFF_SNUM) ||
             (a == rvfy_pkg::OFF_CYLL) || (a == rvfy_pkg::OFF_CYLH) ||
             (a == rvfy_pkg::OFF_DEVHEAD) ||
             (a == rvfy_pkg::OFF_CMD_STATUS) ||
             (a == rvfy_pkg::OFF_ERROR) || (a == rvfy_pkg::OFF_DEVCTL) ||
             (a == rvfy_pkg::OFF_IRQ_STAT) || (a == rvfy_pkg::OFF_IRQ_MASK);
   endfunction : known_addr

   // write channel: address and data are taken in either order
   assign s_axi_awready = ce & ~aw_got_r;
   assign s_axi_wready = ce & ~w_got_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign wr_fire = aw_got_r & w_got_r & ~bvalid_r;
   assign wr_known = known_addr(waddr_r);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         waddr_r <= ZERO8_W;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= rvfy_pkg::RESP_OKAY;
      end else if (ce) begin
         if (s_axi_awvalid && !aw_got_r) begin
            aw_got_r <= 1'b1;
            waddr_r <= {s_axi_awaddr[7:2], 2'h0};
         end
         if (s_axi_wvalid && !w_got_r) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         // respond once both halves are held; freeing them re-arms
         if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_known ? rvfy_pkg::RESP_OKAY : rvfy_pkg::RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
         end
      end
   end

   // task file writes only count while idle and low byte is enabled
   assign tf_wr = wr_fire & wstrb_r[0] & (state_r == rvfy_pkg::ST_IDLE);
   assign cmd_wr = tf_wr & (waddr_r == rvfy_pkg::OFF_CMD_STATUS) &
                   (devhead_r[rvfy_pkg::DH_DEV] == 1'(DEV_NUM));
   // the retry bit of the short opcode is not decoded
   assign is28 = wdata_r[7:1] == rvfy_pkg::OP_VFY28[7:1];
   assign is48 = wdata_r[7:0] == rvfy_pkg::OP_VFY48;
   assign cmd_go = cmd_wr & (is28 | is48);
   assign cmd_bad = cmd_wr & ~(is28 | is48);

   always_comb begin
      if (is48) begin
         cnt_start = {1'b0, prev_r[0], cur_r[0]};
         if (cnt_start == 17'h00000) begin
            cnt_start = rvfy_pkg::CNT48_ZERO;
         end
         addr_start = {prev_r[3], prev_r[2], prev_r[1],
                       cur_r[3], cur_r[2], cur_r[1]};
      end else begin
         cnt_start = {9'h000, cur_r[0]};
         if (cnt_start == 17'h00000) begin
            cnt_start = rvfy_pkg::CNT28_ZERO;
         end
         // chs and lba share one layout: sector/lba0, cylinder/lba1-2,
         // head/lba3 nibble
         addr_start = {20'h00000, devhead_r[3:0],
                       cur_r[3], cur_r[2], cur_r[1]};
      end
   end

   // media answers count only with the done pulse
   assign fin = (state_r == rvfy_pkg::ST_VERIFY) & vfy_done;
   assign fin_bad = fin & (vfy_rsp.unc | vfy_rsp.idnf);
   assign fin_end = fin & (fin_bad | (cnt_r == 17'h00001));
   // a failing sector stays in the count of sectors not verified
   assign rem = fin_bad ? cnt_r : 17'h00000;
   // no data phase: the media is only asked to check sectors
   assign vfy_valid = (state_r == rvfy_pkg::ST_VERIFY);
   assign vfy_req = '{chs: chs_r, ext: ext_r, addr: addr_r};

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= rvfy_pkg::ST_IDLE;
         cnt_r <= 17'h00000;
         addr_r <= 48'h0000_0000_0000;
         ext_r <= 1'b0;
         chs_r <= 1'b0;
      end else if (ce) begin
         unique case (state_r)
            rvfy_pkg::ST_IDLE: begin
               if (cmd_go) begin
                  state_r <= rvfy_pkg::ST_VERIFY;
                  cnt_r <= cnt_start;
                  addr_r <= addr_start;
                  ext_r <= is48;
                  chs_r <= ~is48 & ~devhead_r[rvfy_pkg::DH_LBA];
               end
            end
            rvfy_pkg::ST_VERIFY: begin
               if (vfy_done) begin
                  if (fin_bad) begin
                     state_r <= rvfy_pkg::ST_IDLE;
                  end else if (cnt_r == 17'h00001) begin
                     cnt_r <= 17'h00000;
                     state_r <= rvfy_pkg::ST_IDLE;
                  end else begin
                     cnt_r <= cnt_r - 17'h00001;
                     addr_r <= next_addr(addr_r, chs_r);
                  end
               end
            end
         endcase
      end
   end

   // task file: host writes shift current into previous byte
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) begin
            cur_r[i] <= ZERO8_W;
            prev_r[i] <= ZERO8_W;
         end
         devhead_r <= rvfy_pkg::DEVHEAD_RST;
         devctl_r <= ZERO8_W;
      end else if (ce) begin
         // any count or address write drops the high-order select
         if (tf_wr && waddr_r[7:4] == 4'h0) begin
            prev_r[waddr_r[3:2]] <= cur_r[waddr_r[3:2]];
            cur_r[waddr_r[3:2]] <= wdata_r[7:0];
            devctl_r[rvfy_pkg::CTL_HOB] <= 1'b0;
         end
         if (tf_wr && waddr_r == rvfy_pkg::OFF_DEVHEAD) begin
            devhead_r <= wdata_r[7:0];
         end
         if (wr_fire && wstrb_r[0] && waddr_r == rvfy_pkg::OFF_DEVCTL) begin
            devctl_r <= wdata_r[7:0];
         end
         if (fin_end) begin
            cur_r[0] <= rem[7:0];
            cur_r[1] <= addr_r[7:0];
            cur_r[2] <= addr_r[15:8];
            cur_r[3] <= addr_r[23:16];
            // ext results fill both byte halves, short ones the head
            if (ext_r) begin
               prev_r[0] <= rem[15:8];
               prev_r[1] <= addr_r[31:24];
               prev_r[2] <= addr_r[39:32];
               prev_r[3] <= addr_r[47:40];
            end else begin
               devhead_r[3:0] <= addr_r[27:24];
            end
         end
      end
   end

   // error flags: only unc, idnf and abort are ever raised
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         error_r <= ZERO8_W;
         st_err_r <= 1'b0;
      end else if (ce) begin
         // a new command clears the flags of the last one
         if (cmd_go) begin
            error_r <= ZERO8_W;
            st_err_r <= 1'b0;
         end else if (cmd_bad) begin
            error_r <= ZERO8_W;
            error_r[rvfy_pkg::ERR_ABT] <= 1'b1;
            st_err_r <= 1'b1;
         end else if (fin_bad) begin
            error_r <= ZERO8_W;
            error_r[rvfy_pkg::ERR_UNC] <= vfy_rsp.unc;
            error_r[rvfy_pkg::ERR_IDN] <= ~vfy_rsp.unc;
            st_err_r <= 1'b1;
         end
      end
   end

   // busy from the engine, fault, drq and corrected always clear
   assign status_val = {state_r == rvfy_pkg::ST_VERIFY, 1'b1, 1'b0, 1'b1,
                        1'b0, 1'b0, 1'b0, st_err_r};

   // read channel
   assign s_axi_arready = ce & ~rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign rd_fire = s_axi_arvalid & s_axi_arready;

   always_comb begin
      logic [7:0] ra;
      logic hob;
      ra = {s_axi_araddr[7:2], 2'h0};
      hob = devctl_r[rvfy_pkg::CTL_HOB];
      rd_val = 32'h0000_0000;
      rd_known = known_addr(ra);
      // high-order select shows the previous bytes of the task file
      if (ra[7:4] == 4'h0) begin
         rd_val[7:0] = hob ? prev_r[ra[3:2]] : cur_r[ra[3:2]];
      end else if (ra == rvfy_pkg::OFF_DEVHEAD) begin
         rd_val[7:0] = devhead_r;
      end else if (ra == rvfy_pkg::OFF_CMD_STATUS) begin
         rd_val[7:0] = status_val;
      end else if (ra == rvfy_pkg::OFF_ERROR) begin
         rd_val[7:0] = error_r;
      end else if (ra == rvfy_pkg::OFF_DEVCTL) begin
         rd_val[7:0] = devctl_r;
      end else if (ra == rvfy_pkg::OFF_IRQ_STAT) begin
         rd_val[1:0] = irq_stat_r;
      end else if (ra == rvfy_pkg::OFF_IRQ_MASK) begin
         rd_val[1:0] = irq_mask_r;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= rvfy_pkg::RESP_OKAY;
      end else if (ce) begin
         if (rd_fire) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_val;
            rresp_r <= rd_known ? rvfy_pkg::RESP_OKAY : rvfy_pkg::RESP_SLVERR;
         end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // sticky events; a new event beats a clearing read
   assign irq_set[rvfy_pkg::IRQ_DONE] = fin_end | cmd_bad;
   assign irq_set[rvfy_pkg::IRQ_ERR] = fin_bad | cmd_bad;
   assign irq_clr = (rd_fire && {s_axi_araddr[7:2], 2'h0} ==
                     rvfy_pkg::OFF_IRQ_STAT) ? 2'h3 : 2'h0;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_r <= rvfy_pkg::IRQ_RST;
         irq_mask_r <= rvfy_pkg::IRQ_RST;
      end else if (ce) begin
         irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
         if (wr_fire && wstrb_r[0] &&
             waddr_r == rvfy_pkg::OFF_IRQ_MASK) begin
            irq_mask_r <= wdata_r[1:0];
         end
      end
   end

   // level output, high while any unmasked event is pending
   assign irq = |(irq_stat_r & irq_mask_r);
endmodule : rvfy_top

// File: core/rvfy_top_fix_note.sv
// intentionally empty companion file
`timescale 1ns/1ps

// File: dv/rvfy_media_model.sv
// medium model answering each sector check after a set delay
`timescale 1ns/1ps
module rvfy_media_model (
   input wire logic clock,
   input wire logic rst_n,
   input wire rvfy_pkg::rvfy_media_req_s vfy_req,
   input wire logic vfy_valid,
   input wire logic [3:0] dly,
   input wire logic [47:0] fail_addr,
   input wire rvfy_pkg::rvfy_media_rsp_s fail_rsp,
   output logic vfy_done,
   output rvfy_pkg::rvfy_media_rsp_s vfy_rsp
);
   logic [3:0] cnt_r;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 4'h0;
         vfy_done <= 1'b0;
         vfy_rsp <= 2'h0;
      end else if (vfy_valid && !vfy_done && cnt_r == dly) begin
         cnt_r <= 4'h0;
         vfy_done <= 1'b1;
         vfy_rsp <= (vfy_req.addr == fail_addr) ? fail_rsp : 2'h0;
      end else begin
         cnt_r <= (vfy_valid && !vfy_done) ? cnt_r + 4'h1 : 4'h0;
         vfy_done <= 1'b0;
         // answer is only meaningful with the done pulse
         vfy_rsp <= ~vfy_rsp;
      end
   end
endmodule : rvfy_media_model

// File: dv/rvfy_tb_top.sv
// self-checking bench of the read verify command handler
`timescale 1ns/1ps
module rvfy_tb_top;
   logic clock, rst_n, ce;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, vfy_valid, vfy_done, irq;
   rvfy_pkg::rvfy_media_req_s vfy_req;
   rvfy_pkg::rvfy_media_rsp_s vfy_rsp, fail_rsp;
   logic [3:0] dly;
   logic [47:0] fail_addr;
   int error_cnt = 0;
   int samples_checked = 0;
   int done_cnt = 0;
   rvfy_top i_dut (.clock(clock), .rst_n(rst_n), .ce(ce),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .vfy_req(vfy_req),
      .vfy_valid(vfy_valid), .vfy_done(vfy_done), .vfy_rsp(vfy_rsp),
      .irq(irq));
   rvfy_media_model i_media (.clock(clock), .rst_n(rst_n),
      .vfy_req(vfy_req), .vfy_valid(vfy_valid), .dly(dly),
      .fail_addr(fail_addr), .fail_rsp(fail_rsp), .vfy_done(vfy_done),
      .vfy_rsp(vfy_rsp));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) if (vfy_done) done_cnt <= done_cnt + 1;
   task automatic finish_test();
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, d,
                     input logic [1:0] er = rvfy_pkg::RESP_OKAY);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
   endtask : wr
   task automatic rc(input string nm, input logic [7:0] a,
                     input logic [31:0] exp,
                     input logic [1:0] er = rvfy_pkg::RESP_OKAY);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      chk(nm, s_axi_rdata, exp);
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
   endtask : rc
   task automatic wait_idle();
      do begin
         s_axi_araddr <= rvfy_pkg::OFF_CMD_STATUS;
         s_axi_arvalid <= 1'b1;
         do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
         end while (!s_axi_rvalid);
      end while (s_axi_rdata[7] !== 1'b0);
   endtask : wait_idle
   task automatic irq_chk(input logic [1:0] st);
      chk("irq_set", {31'h0, irq}, {31'h0, |st});
      rc("irq_stat", rvfy_pkg::OFF_IRQ_STAT, {30'h0, st});
      @(posedge clock);
      chk("irq_clr", {31'h0, irq}, 32'h0);
   endtask : irq_chk
   task automatic tf_chk(input logic [7:0] cnt, sn, cl, ch, st, er);
      rc("count", rvfy_pkg::OFF_SCNT, {24'h0, cnt});
      rc("sector", rvfy_pkg::OFF_SNUM, {24'h0, sn});
      rc("cyl_low", rvfy_pkg::OFF_CYLL, {24'h0, cl});
      rc("cyl_high", rvfy_pkg::OFF_CYLH, {24'h0, ch});
      rc("status", rvfy_pkg::OFF_CMD_STATUS, {24'h0, st});
      rc("error", rvfy_pkg::OFF_ERROR, {24'h0, er});
   endtask : tf_chk
   task automatic run28(input logic [7:0] dh, cnt, sn, cl, ch, op);
      wr(rvfy_pkg::OFF_DEVHEAD, dh);
      wr(rvfy_pkg::OFF_SCNT, cnt);
      wr(rvfy_pkg::OFF_SNUM, sn);
      wr(rvfy_pkg::OFF_CYLL, cl);
      wr(rvfy_pkg::OFF_CYLH, ch);
      wr(rvfy_pkg::OFF_CMD_STATUS, op);
      wait_idle();
   endtask : run28
   task automatic t_regs();
      rc("devhead", rvfy_pkg::OFF_DEVHEAD, 32'hA0);
      tf_chk(8'h00, 8'h00, 8'h00, 8'h00, 8'h50, 8'h00);
      rc("unmapped", 8'h28, 32'h0, rvfy_pkg::RESP_SLVERR);
      wr(8'h28, 8'h5A, rvfy_pkg::RESP_SLVERR);
      rc("mask", rvfy_pkg::OFF_IRQ_MASK, 32'h0);
      wr(rvfy_pkg::OFF_IRQ_MASK, 8'h03);
      s_axi_wstrb <= 4'hE;
      wr(rvfy_pkg::OFF_SCNT, 8'h77);
      s_axi_wstrb <= 4'hF;
      rc("strb_low", rvfy_pkg::OFF_SCNT, 32'h0);
      ce <= 1'b0;
      @(posedge clock);
      chk("ce_freeze", {30'h0, s_axi_awready, s_axi_arready}, 32'h0);
      ce <= 1'b1;
   endtask : t_regs
   task automatic t_lba28();
      int n;
      for (int i = 0; i < 2; i++) begin
         n = done_cnt;
         run28(8'hE5, 8'h03, 8'hFE, 8'h4F, 8'h23, 8'h40|8'(i));
         chk("lba_done", 32'(done_cnt - n), 32'h3);
         tf_chk(8'h00, 8'h00, 8'h50, 8'h23, 8'h50, 8'h00);
         rc("lba_head", rvfy_pkg::OFF_DEVHEAD, 32'hE5);
         irq_chk(2'h1);
      end
   endtask : t_lba28
   task automatic t_reject();
      int n;
      n = done_cnt;
      wr(rvfy_pkg::OFF_DEVHEAD, 8'hF0);
      wr(rvfy_pkg::OFF_CMD_STATUS, rvfy_pkg::OP_VFY28);
      rc("other_dev", rvfy_pkg::OFF_CMD_STATUS, 32'h50);
      irq_chk(2'h0);
      wr(rvfy_pkg::OFF_DEVHEAD, 8'hA0);
      wr(rvfy_pkg::OFF_CMD_STATUS, 8'h43);
      tf_chk(8'h00, 8'h00, 8'h50, 8'h23, 8'h51, 8'h04);
      chk("rej_done", 32'(done_cnt - n), 32'h0);
      wr(rvfy_pkg::OFF_IRQ_MASK, 8'h00);
      chk("irq_mask", {31'h0, irq}, 32'h0);
      wr(rvfy_pkg::OFF_IRQ_MASK, 8'h03);
      irq_chk(2'h3);
   endtask : t_reject
   task automatic t_cnt256();
      int n;
      n = done_cnt;
      dly <= 4'h0;
      run28(8'hE0, 8'h00, 8'h00, 8'h00, 8'h00, rvfy_pkg::OP_VFY28);
      chk("n256", 32'(done_cnt - n), 32'h100);
      tf_chk(8'h00, 8'hFF, 8'h00, 8'h00, 8'h50, 8'h00);
      irq_chk(2'h1);
      dly <= 4'h3;
   endtask : t_cnt256
   task automatic t_chs_err();
      int n;
      n = done_cnt;
      fail_addr <= 48'h0000_0000_1101;
      fail_rsp <= 2'h2;
      run28(8'hAF, 8'h05, 8'h3E, 8'h10, 8'h00, rvfy_pkg::OP_VFY28);
      chk("chs_done", 32'(done_cnt - n), 32'h3);
      tf_chk(8'h03, 8'h01, 8'h11, 8'h00, 8'h51, 8'h40);
      rc("chs_head", rvfy_pkg::OFF_DEVHEAD, 32'hA0);
      irq_chk(2'h3);
   endtask : t_chs_err
   task automatic t_ext();
      int n;
      n = done_cnt;
      fail_addr <= 48'hA1B2_C3D4_E600;
      fail_rsp <= 2'h1;
      wr(rvfy_pkg::OFF_DEVHEAD, 8'hE0);
      wr(rvfy_pkg::OFF_SCNT, 8'h00);
      wr(rvfy_pkg::OFF_SCNT, 8'h04);
      wr(rvfy_pkg::OFF_SNUM, 8'hC3);
      wr(rvfy_pkg::OFF_SNUM, 8'hFF);
      wr(rvfy_pkg::OFF_CYLL, 8'hB2);
      wr(rvfy_pkg::OFF_CYLL, 8'hE5);
      wr(rvfy_pkg::OFF_CYLH, 8'hA1);
      wr(rvfy_pkg::OFF_CYLH, 8'hD4);
      wr(rvfy_pkg::OFF_CMD_STATUS, rvfy_pkg::OP_VFY48);
      wait_idle();
      chk("ext_done", 32'(done_cnt - n), 32'h2);
      tf_chk(8'h03, 8'h00, 8'hE6, 8'hD4, 8'h51, 8'h10);
      wr(rvfy_pkg::OFF_DEVCTL, 8'h80);
      tf_chk(8'h00, 8'hC3, 8'hB2, 8'hA1, 8'h51, 8'h10);
      wr(rvfy_pkg::OFF_DEVCTL, 8'h00);
      irq_chk(2'h3);
   endtask : t_ext
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      dly = 4'h1;
      fail_addr = 48'hFFFF_FFFF_FFFF;
      fail_rsp = 2'h0;
      repeat (6) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      t_regs();
      t_lba28();
      t_reject();
      t_cnt256();
      t_chs_err();
      t_ext();
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      finish_test();
   end
endmodule : rvfy_tb_top

// File: dv/rvfy_top_sva.sv
// port assertions of the read verify command handler
`timescale 1ns/1ps
module rvfy_top_sva #(
   parameter logic [7:0] SECT_PER_TRK = 8'h3F,
   parameter logic [3:0] HEAD_MAX = 4'hF
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire rvfy_pkg::rvfy_media_req_s vfy_req,
   input wire logic vfy_valid,
   input wire logic vfy_done,
   input wire rvfy_pkg::rvfy_media_rsp_s vfy_rsp
);
   rvfy_pkg::rvfy_media_req_s req_q_r;
   logic ar_hs_r;
   always_ff @(posedge clock) req_q_r <= vfy_req;
   always_ff @(posedge clock) ar_hs_r <= s_axi_arvalid && s_axi_arready;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence good_s;
      ce && vfy_valid && vfy_done && !(vfy_rsp.unc || vfy_rsp.idnf);
   endsequence
   sequence bad_s;
      ce && vfy_valid && vfy_done && (vfy_rsp.unc || vfy_rsp.idnf);
   endsequence
   write_refuse_a: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   read_only_a: assert property (
      $rose(s_axi_rvalid) |-> ar_hs_r)
      else $error("read data without a read request");
   req_hold_a: assert property (
      vfy_valid && !vfy_done |=> $stable(vfy_req))
      else $error("sector request moved without an answer");
   err_stop_a: assert property (
      bad_s |=> !vfy_valid [*2])
      else $error("verify went on after a failing sector");
   lba_step_a: assert property (
      good_s ##0 !vfy_req.chs |=> !vfy_valid ||
      vfy_req.addr == req_q_r.addr + 48'h1)
      else $error("linear address did not advance by one");
   chs_step_a: assert property (
      good_s ##0 vfy_req.chs |=> !vfy_valid || vfy_req.addr[7:0] ==
      ((req_q_r.addr[7:0] == SECT_PER_TRK) ? 8'h01 :
      req_q_r.addr[7:0] + 8'h01))
      else $error("sector number did not step");
   chs_sect_a: assert property (
      vfy_valid && vfy_req.chs |-> vfy_req.addr[7:0] != 8'h00 &&
      vfy_req.addr[7:0] <= SECT_PER_TRK)
      else $error("sector number out of range");
   chs_head_a: assert property (
      vfy_valid && vfy_req.chs |-> vfy_req.addr[27:24] <= HEAD_MAX)
      else $error("head out of range");
   addr_width_a: assert property (
      vfy_valid && !vfy_req.ext |-> vfy_req.addr[47:28] == 20'h0)
      else $error("short command used upper address bits");
endmodule : rvfy_top_sva
bind rvfy_top rvfy_top_sva #(.SECT_PER_TRK(SECT_PER_TRK), .HEAD_MAX(HEAD_MAX))
   i_sva (.clock(clock), .rst_n(rst_n), .ce(ce),
   .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .vfy_req(vfy_req), .vfy_valid(vfy_valid), .vfy_done(vfy_done),
   .vfy_rsp(vfy_rsp));
